// *** rtl/switch_global_regs.sv ***
// Function
// [R1] polarity bit reads reversal, 10BT only
// [R2] power save enable, zero turns on
// [R3] remote loopback at PMD/PMA when set
// [R4] port one control at 0x10-0x1D
// [R5] port one status at 0x1E-0x1F
// [R6] port two control/status at 0x20-0x2F
// [R7] port three control, reserved, status
// [R8] indirect control and data window
// [R9] link change interrupt at 0xBB-0xBC
// [R10] power/LED 0xC3, sleep 0xC4
// [R11] start bit runs switch, resets one
// [R12] alternative back-off select, resets zero
// [R13] flush dynamic MAC entries, resets zero
// [R14] flush static MAC entries, resets zero
// [R15] pass or drop flow-control packets
// [R16] software writes reserved bits as default
// [R17] read-only bits ignore writes
`timescale 1ns/1ns
`default_nettype none
module switch_global_regs
  import swreg_pkg::*;
#(
  // arbitrary identity values
  parameter logic [7:0] FAMILY_CODE = 8'h5A,
  parameter logic [3:0] PART_CODE   = 4'h6,
  parameter logic [2:0] REV_CODE    = 3'h1
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // byte register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  output logic             REG_RVALID,
  output region_t          REG_REGION,
  // management word port
  input  wire logic [4:0]  PHY_SELECT_ADDRESS,
  input  wire logic [4:0]  PHY_REGISTER_INDEX,
  input  wire logic        MIIM_WR,
  input  wire logic [15:0] MIIM_WDATA,
  input  wire logic        MIIM_RD,
  output logic      [15:0] MIIM_RDATA,
  output logic             MIIM_RVALID,
  // second PHY status pins
  input  wire logic        PHY2_POL_REVERSED,
  input  wire logic        PHY2_MDI_MODE,
  input  wire logic        PHY2_SPEED_10,
  // control outputs
  output logic             SWITCH_RUN,
  output logic             BACKOFF_ALT,
  output logic             FLUSH_DYNAMIC,
  output logic             FLUSH_STATIC,
  output logic             PASS_FLOW_CTRL,
  output logic             PHY2_LINK_FORCE_PASS,
  output logic             PHY2_POWER_SAVE_OFF,
  output logic             PHY2_REMOTE_LOOPBACK
);

  logic        run_r;
  logic        backoff_r;
  logic        flush_dyn_r;
  logic        flush_stat_r;
  logic        pass_fc_r;
  logic        force_r;
  logic        psave_off_r;
  logic        rloop_r;
  logic        rsv0_r;
  logic [7:0]  rdata_r;
  logic        rvalid_r;
  region_t     region_r;
  logic [15:0] mdata_r;
  logic        mvalid_r;
  logic [2:0]  pins_s;
  region_t     region_nxt;
  logic        miim_hit;
  logic        pol_eff;
  logic [15:0] phy_word;
  logic [7:0]  rd_byte;

  pin_sync #(
    .W (3)
  ) u_sync (
    .clk       (CLK),
    .rst       (RST),
    .pin_in    ({PHY2_SPEED_10, PHY2_MDI_MODE, PHY2_POL_REVERSED}),
    .level_out (pins_s)
  );

  addr_region_decode u_dec (
    .addr   (REG_ADDR),
    .region (region_nxt)
  );

  assign miim_hit = (PHY_SELECT_ADDRESS == PHY_TWO_ADDR) &&
                    (PHY_REGISTER_INDEX == PHY_SPECIAL_R);
  // [R1] valid only at 10BT
  assign pol_eff  = pins_s[0] & pins_s[2];

  // reserved upper bits read as zero
  always_comb begin
    phy_word              = 16'h0000;
    phy_word[PHY_POLRVS]  = pol_eff;
    phy_word[PHY_MDI]     = pins_s[1];
    phy_word[PHY_FORCE]   = force_r;
    phy_word[PHY_PWRSAVE] = psave_off_r;
    phy_word[PHY_RLOOP]   = rloop_r;
    phy_word[PHY_RSV0]    = rsv0_r;
  end

  // unimplemented addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (REG_ADDR)
      ADDR_FAMILY: begin
        rd_byte = FAMILY_CODE;
      end
      ADDR_PART_RUN: begin
        rd_byte = {PART_CODE, REV_CODE, run_r};
      end
      ADDR_GCTL0: begin
        rd_byte[GC_BACKOFF]    = backoff_r;
        rd_byte[GC_FLUSH_DYN]  = flush_dyn_r;
        rd_byte[GC_FLUSH_STAT] = flush_stat_r;
        rd_byte[GC_PASS_FC]    = pass_fc_r;
      end
      ADDR_P2_PHYCTL: begin
        rd_byte[PHY_FORCE]   = force_r;
        rd_byte[PHY_PWRSAVE] = psave_off_r;
        rd_byte[PHY_RLOOP]   = rloop_r;
      end
      ADDR_P2_STAT0: begin
        rd_byte[STAT0_MDI] = pins_s[1];
      end
      ADDR_P2_STAT1: begin
        rd_byte[STAT1_POLRVS] = pol_eff;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // [R11] start switch bit
  always_ff @(posedge CLK) begin
    if (RST) begin
      run_r <= RST_RUN;
    end else if (REG_WR && REG_ADDR == ADDR_PART_RUN) begin
      run_r <= REG_WDATA[RUN_BIT];
    end
  end

  // [R17] id and revision bits ignore writes; reserved bits kept zero
  // [R12] [R13] [R14] [R15] global control zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      backoff_r    <= RST_BACKOFF;
      flush_dyn_r  <= RST_FLUSH;
      flush_stat_r <= RST_FLUSH;
      pass_fc_r    <= RST_PASS_FC;
    end else if (REG_WR && REG_ADDR == ADDR_GCTL0) begin
      backoff_r    <= REG_WDATA[GC_BACKOFF];
      flush_dyn_r  <= REG_WDATA[GC_FLUSH_DYN];
      flush_stat_r <= REG_WDATA[GC_FLUSH_STAT];
      pass_fc_r    <= REG_WDATA[GC_PASS_FC];
    end
  end

  // management write wins a same-cycle clash, it carries the full word
  // [R2] [R3] phy special control
  always_ff @(posedge CLK) begin
    if (RST) begin
      force_r     <= RST_FORCE;
      psave_off_r <= RST_PSAVE;
      rloop_r     <= RST_RLOOP;
      rsv0_r      <= RST_RSV0;
    end else if (MIIM_WR && miim_hit) begin
      force_r     <= MIIM_WDATA[PHY_FORCE];
      psave_off_r <= MIIM_WDATA[PHY_PWRSAVE];
      rloop_r     <= MIIM_WDATA[PHY_RLOOP];
      rsv0_r      <= MIIM_WDATA[PHY_RSV0];
    end else if (REG_WR && REG_ADDR == ADDR_P2_PHYCTL) begin
      force_r     <= REG_WDATA[PHY_FORCE];
      psave_off_r <= REG_WDATA[PHY_PWRSAVE];
      rloop_r     <= REG_WDATA[PHY_RLOOP];
    end
  end

  // [R4] [R6] read answer with region
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
      region_r <= RGN_NONE;
    end else begin
      rvalid_r <= REG_RD;
      if (REG_RD) begin
        rdata_r  <= rd_byte;
        region_r <= region_nxt;
      end
    end
  end

  // [R1] management read of special word
  always_ff @(posedge CLK) begin
    if (RST) begin
      mdata_r  <= 16'h0000;
      mvalid_r <= 1'b0;
    end else begin
      mvalid_r <= MIIM_RD;
      if (MIIM_RD) begin
        mdata_r <= miim_hit ? phy_word : 16'h0000;
      end
    end
  end

  assign REG_RDATA            = rdata_r;
  assign REG_RVALID           = rvalid_r;
  assign REG_REGION           = region_r;
  assign MIIM_RDATA           = mdata_r;
  assign MIIM_RVALID          = mvalid_r;
  assign SWITCH_RUN           = run_r;
  assign BACKOFF_ALT          = backoff_r;
  assign FLUSH_DYNAMIC        = flush_dyn_r;
  assign FLUSH_STATIC         = flush_stat_r;
  assign PASS_FLOW_CTRL       = pass_fc_r;
  assign PHY2_LINK_FORCE_PASS = force_r;
  assign PHY2_POWER_SAVE_OFF  = psave_off_r;
  assign PHY2_REMOTE_LOOPBACK = rloop_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_miim_wr_special;
    MIIM_WR && miim_hit;
  endsequence
  sequence s_byte_wr(logic [7:0] a);
    REG_WR && REG_ADDR == a;
  endsequence
  sequence s_byte_rd(logic [7:0] a);
    REG_RD && REG_ADDR == a;
  endsequence

  a_run_write: assert property ( // [R11]
    s_byte_wr(ADDR_PART_RUN) |=> SWITCH_RUN == $past(REG_WDATA[RUN_BIT]))
    else $error("start bit not taken");
  a_backoff_sel: assert property ( // [R12]
    s_byte_wr(ADDR_GCTL0) |=> BACKOFF_ALT == $past(REG_WDATA[GC_BACKOFF]))
    else $error("back-off select wrong");
  a_flush_dyn: assert property ( // [R13]
    s_byte_wr(ADDR_GCTL0) |=> FLUSH_DYNAMIC == $past(REG_WDATA[GC_FLUSH_DYN]))
    else $error("dynamic flush wrong");
  a_flush_stat: assert property ( // [R14]
    s_byte_wr(ADDR_GCTL0) |=> FLUSH_STATIC == $past(REG_WDATA[GC_FLUSH_STAT]))
    else $error("static flush wrong");
  a_pass_fc: assert property ( // [R15]
    !(REG_WR && REG_ADDR == ADDR_GCTL0) |=> $stable(PASS_FLOW_CTRL))
    else $error("flow control pass changed");
  a_power_save: assert property ( // [R2]
    s_miim_wr_special |=> PHY2_POWER_SAVE_OFF == $past(MIIM_WDATA[PHY_PWRSAVE]))
    else $error("power save bit wrong");
  a_remote_loop: assert property ( // [R3]
    s_miim_wr_special |=> PHY2_REMOTE_LOOPBACK == $past(MIIM_WDATA[PHY_RLOOP]))
    else $error("loopback bit wrong");
  a_polarity_rd: assert property ( // [R1]
    MIIM_RD && miim_hit |=> MIIM_RVALID && MIIM_RDATA[PHY_POLRVS] ==
                           $past(pins_s[0] & pins_s[2]))
    else $error("polarity read wrong");
  a_family_ro: assert property ( // [R17]
    REG_RD && REG_ADDR == ADDR_FAMILY |=> REG_RVALID && REG_RDATA == FAMILY_CODE)
    else $error("identity changed");
  a_p1_region: assert property ( // [R4]
    REG_RD && in_range(REG_ADDR, P1C_LO, P1C_HI) |=> REG_REGION == RGN_P1_CTL)
    else $error("port one control decode wrong");
  a_p3_stat: assert property ( // [R7]
    REG_RD && REG_ADDR == P3S_ADR |=> REG_REGION == RGN_P3_STAT ##1 1'b1)
    else $error("port three status decode wrong");

  // read in the same cycle as a write sees the old value
  a_power_rdback: assert property ( // [R2]
    MIIM_RD && miim_hit |=> MIIM_RDATA[PHY_PWRSAVE] == $past(PHY2_POWER_SAVE_OFF))
    else $error("power save read back wrong");
  a_pass_fc_wr: assert property ( // [R15]
    s_byte_wr(ADDR_GCTL0) |=> PASS_FLOW_CTRL == $past(REG_WDATA[GC_PASS_FC]))
    else $error("flow control pass not taken");
  a_loop_byte: assert property ( // [R3]
    REG_WR && REG_ADDR == ADDR_P2_PHYCTL && !(MIIM_WR && miim_hit)
      |=> PHY2_REMOTE_LOOPBACK == $past(REG_WDATA[PHY_RLOOP]))
    else $error("loopback byte write wrong");
  a_part_ro: assert property ( // [R17]
    s_byte_rd(ADDR_PART_RUN) |=> REG_RDATA[7:1] == {PART_CODE, REV_CODE})
    else $error("part identity changed");
  a_stat_pol: assert property ( // [R1]
    s_byte_rd(ADDR_P2_STAT1) |=> REG_RDATA[STAT1_POLRVS] == $past(pol_eff))
    else $error("polarity status byte wrong");
  a_p1s_region: assert property ( // [R5]
    REG_RD && in_range(REG_ADDR, P1S_LO, P1S_HI) |=> REG_REGION == RGN_P1_STAT)
    else $error("port one status decode wrong");
  a_p2s_region: assert property ( // [R6]
    REG_RD && in_range(REG_ADDR, P2S_LO, P2S_HI) |=> REG_REGION == RGN_P2_STAT)
    else $error("port two status decode wrong");
  a_rsvd_region: assert property ( // [R7]
    REG_RD && in_range(REG_ADDR, P3R_LO, P3R_HI) |=> REG_REGION == RGN_RSVD)
    else $error("reserved block decode wrong");
  a_ind_region: assert property ( // [R8]
    REG_RD && in_range(REG_ADDR, INDD_LO, INDD_HI) |=> REG_REGION == RGN_IND_DATA)
    else $error("indirect data decode wrong");
  a_lci_region: assert property ( // [R9]
    REG_RD && in_range(REG_ADDR, LCI_LO, LCI_HI) |=> REG_REGION == RGN_LINK_IRQ)
    else $error("link change decode wrong");
  a_sleep_region: assert property ( // [R10]
    s_byte_rd(SLEEP_A) |=> REG_REGION == RGN_SLEEP)
    else $error("sleep register decode wrong");

endmodule // switch_global_regs
`default_nettype wire

// *** common/swreg_pkg.sv ***
`default_nettype none
package swreg_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_FAMILY    = 8'h00;
  localparam logic [7:0] ADDR_PART_RUN  = 8'h01;
  localparam logic [7:0] ADDR_GCTL0     = 8'h02;
  localparam logic [7:0] ADDR_P2_PHYCTL = 8'h2A;
  localparam logic [7:0] ADDR_P2_STAT0  = 8'h2E;
  localparam logic [7:0] ADDR_P2_STAT1  = 8'h2F;

  // address map bounds
  localparam logic [7:0] GLB_LO  = 8'h00;
  localparam logic [7:0] GLB_HI  = 8'h0F;
  localparam logic [7:0] P1C_LO  = 8'h10;
  localparam logic [7:0] P1C_HI  = 8'h1D;
  localparam logic [7:0] P1S_LO  = 8'h1E;
  localparam logic [7:0] P1S_HI  = 8'h1F;
  localparam logic [7:0] P2C_LO  = 8'h20;
  localparam logic [7:0] P2C_HI  = 8'h2D;
  localparam logic [7:0] P2S_LO  = 8'h2E;
  localparam logic [7:0] P2S_HI  = 8'h2F;
  localparam logic [7:0] P3C_LO  = 8'h30;
  localparam logic [7:0] P3C_HI  = 8'h39;
  localparam logic [7:0] P3R_LO  = 8'h3A;
  localparam logic [7:0] P3R_HI  = 8'h3E;
  localparam logic [7:0] P3S_ADR = 8'h3F;
  localparam logic [7:0] INDC_LO = 8'h79;
  localparam logic [7:0] INDC_HI = 8'h7A;
  localparam logic [7:0] INDD_LO = 8'h7B;
  localparam logic [7:0] INDD_HI = 8'h83;
  localparam logic [7:0] LCI_LO  = 8'hBB;
  localparam logic [7:0] LCI_HI  = 8'hBC;
  localparam logic [7:0] PMLED_A = 8'hC3;
  localparam logic [7:0] SLEEP_A = 8'hC4;

  typedef enum logic [3:0] {
    RGN_NONE     = 4'h0,
    RGN_GLOBAL   = 4'h1,
    RGN_P1_CTL   = 4'h2,
    RGN_P1_STAT  = 4'h3,
    RGN_P2_CTL   = 4'h4,
    RGN_P2_STAT  = 4'h5,
    RGN_P3_CTL   = 4'h6,
    RGN_RSVD     = 4'h7,
    RGN_P3_STAT  = 4'h8,
    RGN_IND_CTL  = 4'h9,
    RGN_IND_DATA = 4'hA,
    RGN_LINK_IRQ = 4'hB,
    RGN_PM_LED   = 4'hC,
    RGN_SLEEP    = 4'hD
  } region_t;

  // field positions
  localparam int RUN_BIT       = 0;
  localparam int GC_BACKOFF    = 7;
  localparam int GC_FLUSH_DYN  = 5;
  localparam int GC_FLUSH_STAT = 4;
  localparam int GC_PASS_FC    = 3;
  localparam int PHY_POLRVS    = 5;
  localparam int PHY_MDI       = 4;
  localparam int PHY_FORCE     = 3;
  localparam int PHY_PWRSAVE   = 2;
  localparam int PHY_RLOOP     = 1;
  localparam int PHY_RSV0      = 0;
  localparam int STAT0_MDI     = 7;
  localparam int STAT1_POLRVS  = 5;
  localparam int ID_PART_LSB   = 4;
  localparam int ID_REV_LSB    = 1;

  // reset values
  localparam logic RST_RUN      = 1'b1;
  localparam logic RST_PSAVE    = 1'b1;
  localparam logic RST_BACKOFF  = 1'b0;
  localparam logic RST_FLUSH    = 1'b0;
  localparam logic RST_PASS_FC  = 1'b0;
  localparam logic RST_FORCE    = 1'b0;
  localparam logic RST_RLOOP    = 1'b0;
  localparam logic RST_RSV0     = 1'b0;

  // management addressing of the special word
  localparam logic [4:0] PHY_TWO_ADDR  = 5'h02;
  localparam logic [4:0] PHY_SPECIAL_R = 5'h1F;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

endpackage
`default_nettype wire

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;
  logic [W-1:0] agree;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a level counts once the last two stages agree, so a lone glitch never passes
  assign agree = ~(s2_r ^ s3_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      level_r <= '0;
    end else begin
      level_r <= (agree & s3_r) | (~agree & level_r);
    end
  end

  assign level_out = level_r;
endmodule // pin_sync
`default_nettype wire

// *** rtl/addr_region_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module addr_region_decode
  import swreg_pkg::*;
(
  input  wire logic [7:0] addr,
  output region_t         region
);
  always_comb begin
    if (in_range(addr, GLB_LO, GLB_HI)) begin
      region = RGN_GLOBAL;
    // [R4] port one control
    end else if (in_range(addr, P1C_LO, P1C_HI)) begin
      region = RGN_P1_CTL;
    // [R5] port one status
    end else if (in_range(addr, P1S_LO, P1S_HI)) begin
      region = RGN_P1_STAT;
    // [R6] port two blocks
    end else if (in_range(addr, P2C_LO, P2C_HI)) begin
      region = RGN_P2_CTL;
    end else if (in_range(addr, P2S_LO, P2S_HI)) begin
      region = RGN_P2_STAT;
    // [R7] processor port blocks
    end else if (in_range(addr, P3C_LO, P3C_HI)) begin
      region = RGN_P3_CTL;
    end else if (in_range(addr, P3R_LO, P3R_HI)) begin
      region = RGN_RSVD;
    end else if (addr == P3S_ADR) begin
      region = RGN_P3_STAT;
    // [R8] indirect access window
    end else if (in_range(addr, INDC_LO, INDC_HI)) begin
      region = RGN_IND_CTL;
    end else if (in_range(addr, INDD_LO, INDD_HI)) begin
      region = RGN_IND_DATA;
    // [R9] link change interrupt
    end else if (in_range(addr, LCI_LO, LCI_HI)) begin
      region = RGN_LINK_IRQ;
    // [R10] power and sleep
    end else if (addr == PMLED_A) begin
      region = RGN_PM_LED;
    end else if (addr == SLEEP_A) begin
      region = RGN_SLEEP;
    end else begin
      region = RGN_NONE;
    end
  end
endmodule // addr_region_decode
`default_nettype wire

// *** bench/host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // clock
  input  wire logic        CLK,
  // byte register port
  output logic      [7:0]  REG_ADDR,
  output logic             REG_WR,
  output logic      [7:0]  REG_WDATA,
  output logic             REG_RD,
  // management word port
  output logic      [4:0]  PHY_SELECT_ADDRESS,
  output logic      [4:0]  PHY_REGISTER_INDEX,
  output logic             MIIM_WR,
  output logic      [15:0] MIIM_WDATA,
  output logic             MIIM_RD
);
  initial begin
    REG_ADDR = 8'h00;
    REG_WR = 1'b0;
    REG_WDATA = 8'h00;
    REG_RD = 1'b0;
    PHY_SELECT_ADDRESS = 5'h00;
    PHY_REGISTER_INDEX = 5'h00;
    MIIM_WR = 1'b0;
    MIIM_WDATA = 16'h0000;
    MIIM_RD = 1'b0;
  end

  // released lines show the inverse, so stale values never pass for data
  task automatic byte_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= wr;
    REG_RD <= ~wr;
    @(posedge CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    REG_ADDR <= ~a;
    REG_WDATA <= ~d;
  endtask

  task automatic mii_op(input logic wr, input logic [4:0] p, input logic [4:0] i,
                        input logic [15:0] d);
    @(posedge CLK);
    PHY_SELECT_ADDRESS <= p;
    PHY_REGISTER_INDEX <= i;
    MIIM_WDATA <= d;
    MIIM_WR <= wr;
    MIIM_RD <= ~wr;
    @(posedge CLK);
    MIIM_WR <= 1'b0;
    MIIM_RD <= 1'b0;
    PHY_SELECT_ADDRESS <= ~p;
    PHY_REGISTER_INDEX <= ~i;
    MIIM_WDATA <= ~d;
  endtask
endmodule // host_model
`default_nettype wire

// *** bench/tb_switch_global_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_switch_global_regs;
  import swreg_pkg::*;
  // arbitrary identity values
  localparam logic [7:0] FAM = 8'hA7;
  localparam logic [3:0] PRT = 4'h9;
  localparam logic [2:0] REV = 3'h5;

  logic        clk, rst, pol, mdi, spd10;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ctl;
  logic        reg_wr, reg_rd, reg_rvalid, miim_wr, miim_rd, miim_rvalid;
  region_t     reg_region;
  logic [4:0]  phy_sel, phy_idx;
  logic [15:0] miim_wdata, miim_rdata;
  logic        run, boff, fdyn, fstat, pfc, lforce, psoff, rloop;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [7:0]  ra [25] = '{8'h0F, 8'h10, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h2D, 8'h2E, 8'h2F,
    8'h30, 8'h39, 8'h3A, 8'h3E, 8'h3F, 8'h40, 8'h79, 8'h7A, 8'h7B, 8'h83, 8'h84, 8'hBB,
    8'hBC, 8'hBD, 8'hC3, 8'hC4};
  region_t     rr [25] = '{RGN_GLOBAL, RGN_P1_CTL, RGN_P1_CTL, RGN_P1_STAT, RGN_P1_STAT,
    RGN_P2_CTL, RGN_P2_CTL, RGN_P2_STAT, RGN_P2_STAT, RGN_P3_CTL, RGN_P3_CTL, RGN_RSVD,
    RGN_RSVD, RGN_P3_STAT, RGN_NONE, RGN_IND_CTL, RGN_IND_CTL, RGN_IND_DATA, RGN_IND_DATA,
    RGN_NONE, RGN_LINK_IRQ, RGN_LINK_IRQ, RGN_NONE, RGN_PM_LED, RGN_SLEEP};

  assign ctl = {run, boff, fdyn, fstat, pfc, lforce, psoff, rloop};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  host_model u_host (.CLK(clk), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
    .REG_RD(reg_rd), .PHY_SELECT_ADDRESS(phy_sel), .PHY_REGISTER_INDEX(phy_idx),
    .MIIM_WR(miim_wr), .MIIM_WDATA(miim_wdata), .MIIM_RD(miim_rd));

  switch_global_regs #(.FAMILY_CODE(FAM), .PART_CODE(PRT), .REV_CODE(REV)) u_dut (
    .CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .REG_REGION(reg_region),
    .PHY_SELECT_ADDRESS(phy_sel), .PHY_REGISTER_INDEX(phy_idx), .MIIM_WR(miim_wr),
    .MIIM_WDATA(miim_wdata), .MIIM_RD(miim_rd), .MIIM_RDATA(miim_rdata),
    .MIIM_RVALID(miim_rvalid), .PHY2_POL_REVERSED(pol), .PHY2_MDI_MODE(mdi),
    .PHY2_SPEED_10(spd10), .SWITCH_RUN(run), .BACKOFF_ALT(boff), .FLUSH_DYNAMIC(fdyn),
    .FLUSH_STATIC(fstat), .PASS_FLOW_CTRL(pfc), .PHY2_LINK_FORCE_PASS(lforce),
    .PHY2_POWER_SAVE_OFF(psoff), .PHY2_REMOTE_LOOPBACK(rloop));

  task automatic wrap_up();
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // answers land on the taking edge and are read 1 ns after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.byte_op(1'b1, a, d);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    u_host.byte_op(1'b0, a, 8'h00);
    #1;
    chk(reg_rvalid, 16'h0001);
    v = reg_rdata;
  endtask

  task automatic mwr(input logic [4:0] p, input logic [15:0] d);
    u_host.mii_op(1'b1, p, PHY_SPECIAL_R, d);
    #1;
  endtask

  task automatic mrd(input logic [4:0] p, output logic [15:0] w);
    u_host.mii_op(1'b0, p, PHY_SPECIAL_R, 16'h0000);
    #1;
    chk(miim_rvalid, 16'h0001);
    w = miim_rdata;
  endtask

  task automatic defaults();
    logic [7:0]  v;
    logic [15:0] w;
    chk(ctl, 8'h82);
    rd(ADDR_FAMILY, v);
    chk(v, FAM);
    rd(ADDR_PART_RUN, v);
    chk(v, {PRT, REV, 1'b1});
    rd(ADDR_GCTL0, v);
    chk(v, 8'h00);
    mrd(PHY_TWO_ADDR, w);
    chk(w, 16'h0004);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    logic [7:0]  v;
    logic [7:0]  g;
    logic [15:0] w;
    rst <= 1'b1;
    pol <= 1'b0;
    mdi <= 1'b0;
    spd10 <= 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    defaults();
    // one control bit at a time; reserved bits must not stick
    for (int b = 0; b < 8; b++) begin
      g = 8'h01 << b;
      wr(ADDR_GCTL0, g);
      chk(ctl, {1'b1, g[7], g[5], g[4], g[3], 3'b010});
      rd(ADDR_GCTL0, v);
      chk(v, g & 8'hB8);
    end
    wr(ADDR_GCTL0, 8'h00);
    chk(ctl, 8'h82);
    wr(ADDR_FAMILY, 8'hFF);
    rd(ADDR_FAMILY, v);
    chk(v, FAM);
    wr(ADDR_PART_RUN, 8'h00);
    chk(run, 1'b0);
    rd(ADDR_PART_RUN, v);
    chk(v, {PRT, REV, 1'b0});
    wr(ADDR_PART_RUN, 8'hFF);
    chk(run, 1'b1);
    for (int k = 0; k < 25; k++) begin
      rd(ra[k], v);
      chk(reg_region, rr[k]);
      if (rr[k] == RGN_NONE) chk(v, 8'h00);
    end
    // reserved bit 0 written at default, upper read-only bits written on purpose
    mwr(PHY_TWO_ADDR, 16'hFFFE);
    mrd(PHY_TWO_ADDR, w);
    chk(w, 16'h000E);
    chk(ctl, 8'h87);
    rd(ADDR_P2_PHYCTL, v);
    chk(v & 8'h0E, 8'h0E);
    mwr(PHY_TWO_ADDR, 16'h0000);
    chk(ctl, 8'h80);
    wr(ADDR_P2_PHYCTL, 8'h0A);
    chk(ctl, 8'h85);
    mrd(PHY_TWO_ADDR, w);
    chk(w, 16'h000A);
    mwr(5'h01, 16'h0004);
    chk(ctl, 8'h85);
    mrd(5'h01, w);
    chk(w, 16'h0000);
    @(posedge clk);
    pol <= 1'b1;
    mdi <= 1'b1;
    spd10 <= 1'b1;
    repeat (5) @(posedge clk);
    mrd(PHY_TWO_ADDR, w);
    chk(w, 16'h003A);
    rd(ADDR_P2_STAT1, v);
    chk(v & 8'h20, 8'h20);
    rd(ADDR_P2_STAT0, v);
    chk(v & 8'h80, 8'h80);
    @(posedge clk);
    spd10 <= 1'b0;
    repeat (5) @(posedge clk);
    mrd(PHY_TWO_ADDR, w);
    chk(w, 16'h001A);
    // second reset mid-run must restore every default
    @(posedge clk);
    rst <= 1'b1;
    pol <= 1'b0;
    mdi <= 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    defaults();
    wrap_up();
  end
endmodule // tb_switch_global_regs
`default_nettype wire
